// ---- pkg/gpio_port_defines.vh ----
/*
 * register map, field layout and mode encodings of the eight-pin port.
 * assumes inclusion by bare name from the port design file.
 */
`ifndef GPIO_PORT_DEFINES_VH
`define GPIO_PORT_DEFINES_VH

`define PIN_COUNT 8
`define ADDR_W 8

`define OFF_DIR 8'h00
`define OFF_DIR_SET 8'h04
`define OFF_DIR_CLR 8'h08
`define OFF_DIR_TGL 8'h0C
`define OFF_OUT 8'h10
`define OFF_OUT_SET 8'h14
`define OFF_OUT_CLR 8'h18
`define OFF_OUT_TGL 8'h1C
`define OFF_IN 8'h20
`define OFF_MASK0 8'h24
`define OFF_MASK1 8'h28
`define OFF_CFG_SEL 8'h2C
`define OFF_CFG 8'h30
`define OFF_STATUS 8'h34
`define OFF_IRQ_EN 8'h38
`define OFF_ROUTE 8'h3C

`define CFG_SENSE_LSB 0
`define CFG_SENSE_MSB 1
`define CFG_DRV_LSB 2
`define CFG_DRV_MSB 4
`define CFG_INV_BIT 5
`define CFG_W 6
`define CFG_RESET 6'h00

`define SENSE_BOTH 2'h0
`define SENSE_RISE 2'h1
`define SENSE_FALL 2'h2
`define SENSE_LOW 2'h3

`define DRV_TOTEM 3'h0
`define DRV_PULLDN 3'h1
`define DRV_PULLUP 3'h2
`define DRV_KEEPER 3'h3
`define DRV_WOR 3'h4
`define DRV_WAND 3'h5

`define ROUTE_CLK_EN_BIT 0
`define ROUTE_EVT_EN_BIT 1
`define ROUTE_CLK_PIN_LSB 4
`define ROUTE_CLK_PIN_MSB 6
`define EVT_PIN 3'h7

`define ST_INT0_BIT 0
`define ST_INT1_BIT 1

`endif

// ---- rtl/gpio_port.v ----
/*
 * eight-pin general purpose port with per-pin config, sense and two irqs.
 * assumes an apb master on pclk; pins synchronised here, peripheral lines used unsynchronised.
 */
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "gpio_port_defines.vh"

// Function
// - eight pins numbered zero to seven, each configured on its own.
// - direction chosen per pin as input or output.
// - one config write may update several pins selected together.
// - input inversion flips pin value before the readable input value.
// - output inversion flips output register value before the pin.
// - inversion also applies when a peripheral drives the pin.
// - per-pin drive: totem, pull-up, pull-down, wired-and, wired-or, keeper.
// - keeper weakly holds last driven level, pulling up or down.
// - sense both, rising, falling or low level; sync or async.
// - inversion is applied before the sense logic.
// - asynchronous wake-up from every sense setting without clock.
// - two independent interrupt outputs per port.
// - per-pin mask for each of the two interrupts.
// - interrupt raised when unmasked pin meets its sense condition.
// - set, clear, toggle locations for output and direction, ones only.
// - optional system clock driven out onto a port pin.
// - optional event channel zero driven onto pin seven.
// - peripheral alternate function overrides general purpose output.
module gpio_port (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [7:0] port_pin_n_in,
    output wire [7:0] port_pin_n_out,
    output wire [7:0] port_pin_n_oe,
    output wire [7:0] pull_up_en,
    output wire [7:0] pull_dn_en,
    input wire [7:0] alt_en,
    input wire [7:0] alt_out,
    input wire [7:0] alt_oe,
    output wire [7:0] alt_in,
    input wire sys_clk_out,
    input wire evt_ch0,
    output wire wake_async,
    output wire irq0,
    output wire irq1,
    output wire irq
);

////////////////////////////////////////////////////////////////////////
// registers and apb decode

reg [7:0] dir_r;
reg [7:0] out_r;
reg [7:0] mask0_r;
reg [7:0] mask1_r;
reg [7:0] cfg_sel_r;
reg [`CFG_W-1:0] cfg_r [0:`PIN_COUNT-1];
reg [1:0] status_r;
reg [1:0] irq_en_r;
reg [6:0] route_r;
reg [7:0] sync1_r;
reg [7:0] sync2_r;
reg [7:0] sense_prev_r;
reg [7:0] keep_r;

wire wr = psel & penable & pwrite;
wire rd = psel & penable & ~pwrite;
wire [7:0] wd = pwdata[7:0];
wire mapped = (paddr <= `OFF_ROUTE) && (paddr[1:0] == 2'h0);
wire [7:0] in_val;
wire [1:0] hit;
integer i;
integer k;

assign pready = 1'b1;
assign pslverr = psel & penable & ~mapped;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        dir_r <= 8'h00;
        out_r <= 8'h00;
        mask0_r <= 8'h00;
        mask1_r <= 8'h00;
        cfg_sel_r <= 8'h00;
        irq_en_r <= 2'h0;
        route_r <= 7'h00;
        for (k = 0; k < `PIN_COUNT; k = k + 1) begin
            cfg_r[k] <= `CFG_RESET;
        end
    end else if (wr) begin
        case (paddr)
            `OFF_DIR: dir_r <= wd;
            `OFF_DIR_SET: dir_r <= dir_r | wd;
            `OFF_DIR_CLR: dir_r <= dir_r & ~wd;
            `OFF_DIR_TGL: dir_r <= dir_r ^ wd;
            `OFF_OUT: out_r <= wd;
            `OFF_OUT_SET: out_r <= out_r | wd;
            `OFF_OUT_CLR: out_r <= out_r & ~wd;
            `OFF_OUT_TGL: out_r <= out_r ^ wd;
            `OFF_MASK0: mask0_r <= wd;
            `OFF_MASK1: mask1_r <= wd;
            `OFF_CFG_SEL: cfg_sel_r <= wd;
            `OFF_CFG: begin
                for (k = 0; k < `PIN_COUNT; k = k + 1) begin
                    if (cfg_sel_r[k]) begin
                        cfg_r[k] <= pwdata[`CFG_W-1:0];
                    end
                end
            end
            `OFF_IRQ_EN: irq_en_r <= pwdata[1:0];
            `OFF_ROUTE: route_r <= pwdata[6:0];
            default: ;
        endcase
    end
end

always @* begin
    prdata = 32'h0000_0000;
    if (rd) begin
        case (paddr)
            `OFF_DIR, `OFF_DIR_SET, `OFF_DIR_CLR, `OFF_DIR_TGL:
                prdata = {24'h000000, dir_r};
            `OFF_OUT, `OFF_OUT_SET, `OFF_OUT_CLR, `OFF_OUT_TGL:
                prdata = {24'h000000, out_r};
            `OFF_IN: prdata = {24'h000000, in_val};
            `OFF_MASK0: prdata = {24'h000000, mask0_r};
            `OFF_MASK1: prdata = {24'h000000, mask1_r};
            `OFF_CFG_SEL: prdata = {24'h000000, cfg_sel_r};
            `OFF_STATUS: prdata = {30'h00000000, status_r};
            `OFF_IRQ_EN: prdata = {30'h00000000, irq_en_r};
            `OFF_ROUTE: prdata = {25'h0000000, route_r};
            default: prdata = 32'h0000_0000;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// per-pin input path, sense and driver

reg [7:0] inv;
reg [7:0] sense_hit;
reg [7:0] out_src;
reg [7:0] oe_src;
reg [7:0] pin_o;
reg [7:0] pin_oe;
reg [7:0] pu;
reg [7:0] pd;
reg [7:0] wake;
reg [2:0] drv;
reg [1:0] sm;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sync1_r <= 8'h00;
        sync2_r <= 8'h00;
        sense_prev_r <= 8'h00;
        keep_r <= 8'h00;
    end else begin
        sync1_r <= port_pin_n_in;
        sync2_r <= sync1_r;
        sense_prev_r <= in_val;
        keep_r <= (pin_oe & pin_o) | (~pin_oe & keep_r);
    end
end

assign in_val = sync2_r ^ inv;
assign alt_in = in_val;

always @* begin
    for (i = 0; i < `PIN_COUNT; i = i + 1) begin
        inv[i] = cfg_r[i][`CFG_INV_BIT];
        sm = cfg_r[i][`CFG_SENSE_MSB:`CFG_SENSE_LSB];
        drv = cfg_r[i][`CFG_DRV_MSB:`CFG_DRV_LSB];
        case (sm)
            `SENSE_BOTH: sense_hit[i] = in_val[i] ^ sense_prev_r[i];
            `SENSE_RISE: sense_hit[i] = in_val[i] & ~sense_prev_r[i];
            `SENSE_FALL: sense_hit[i] = ~in_val[i] & sense_prev_r[i];
            `SENSE_LOW: sense_hit[i] = ~in_val[i];
            default: sense_hit[i] = 1'b0;
        endcase
        // clockless wake: raw pin level against sense setting
        case (sm)
            `SENSE_RISE: wake[i] = port_pin_n_in[i] ^ inv[i];
            `SENSE_FALL, `SENSE_LOW: wake[i] = ~(port_pin_n_in[i] ^ inv[i]);
            default: wake[i] = (port_pin_n_in[i] ^ inv[i]) ^ sync2_r[i];
        endcase
        // source select: peripheral, event, clock, then port
        out_src[i] = out_r[i];
        oe_src[i] = dir_r[i];
        if (route_r[`ROUTE_CLK_EN_BIT] &&
            route_r[`ROUTE_CLK_PIN_MSB:`ROUTE_CLK_PIN_LSB] == i[2:0]) begin
            out_src[i] = sys_clk_out;
        end
        if (route_r[`ROUTE_EVT_EN_BIT] && i[2:0] == `EVT_PIN) begin
            out_src[i] = evt_ch0;
        end
        if (alt_en[i]) begin
            out_src[i] = alt_out[i];
            oe_src[i] = alt_oe[i];
        end
        pin_o[i] = out_src[i] ^ inv[i];
        pin_oe[i] = oe_src[i];
        pu[i] = 1'b0;
        pd[i] = 1'b0;
        case (drv)
            `DRV_TOTEM: ;
            `DRV_PULLDN: pd[i] = ~oe_src[i];
            `DRV_PULLUP: pu[i] = ~oe_src[i];
            `DRV_KEEPER: begin
                pu[i] = ~oe_src[i] & keep_r[i];
                pd[i] = ~oe_src[i] & ~keep_r[i];
            end
            `DRV_WOR: begin
                pin_oe[i] = oe_src[i] & pin_o[i];
                pd[i] = 1'b1;
            end
            `DRV_WAND: begin
                pin_oe[i] = oe_src[i] & ~pin_o[i];
                pu[i] = 1'b1;
            end
            default: ;
        endcase
    end
end

assign port_pin_n_out = pin_o;
assign port_pin_n_oe = pin_oe;
assign pull_up_en = pu;
assign pull_dn_en = pd;
assign wake_async = |(wake & (mask0_r | mask1_r));

////////////////////////////////////////////////////////////////////////
// two port interrupts

assign hit[0] = |(sense_hit & mask0_r);
assign hit[1] = |(sense_hit & mask1_r);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        status_r <= 2'h0;
    end else begin
        // set wins over read clear
        if (rd && paddr == `OFF_STATUS) begin
            status_r <= hit;
        end else begin
            status_r <= status_r | hit;
        end
    end
end

assign irq0 = status_r[`ST_INT0_BIT] & irq_en_r[`ST_INT0_BIT];
assign irq1 = status_r[`ST_INT1_BIT] & irq_en_r[`ST_INT1_BIT];
assign irq = irq0 | irq1;

endmodule

// ---- verif/board_pins.sv ----
/* board side of the eight port pins.
   assumes drive, enable and pull outputs of gpio_port. */
`timescale 1ns/100ps
module board_pins (
    input wire [7:0] drv,
    input wire [7:0] oe,
    input wire [7:0] pu,
    input wire [7:0] pd,
    input wire [7:0] ext,
    output wire [7:0] pin
);
    // driven level, else pull, else board source
    assign pin = (oe & drv) | (~oe & pu) | (~oe & ~pu & ~pd & ext);
endmodule

// ---- verif/gpio_port_props.sv ----
/* assertions on apb answers and irq outputs of gpio_port.
   assumes binding onto gpio_port, one clock pclk. */
`timescale 1ns/100ps
`include "gpio_port_defines.vh"
module gpio_port_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire irq0,
    input wire irq1,
    input wire irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel & penable;
    wire clr = acc & ~pwrite & (paddr == `OFF_STATUS);
    wire hold = ~clr & ~(acc & pwrite);
    ready_a: assert property (acc |-> pready)
        else $error("no ready");
    bad_addr_a: assert property (
        acc && paddr > 8'h3C |-> pslverr && prdata == 32'h0)
        else $error("unmapped not refused");
    err_idle_a: assert property (!acc |-> !pslverr)
        else $error("stray error");
    rd_idle_a: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
        else $error("stray read data");
    rd_upper_a: assert property (acc |-> prdata[31:8] == 24'h0)
        else $error("upper bits set");
    irq_or_a: assert property (irq == (irq0 | irq1))
        else $error("irq not or");
    sticky0_a: assert property (irq0 && hold |=> irq0)
        else $error("irq0 dropped");
    sticky1_a: assert property (irq1 && hold |=> irq1)
        else $error("irq1 dropped");
endmodule
bind gpio_port gpio_port_chk u_gpio_port_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq0(irq0), .irq1(irq1), .irq(irq));

// ---- verif/tb_gpio_port.sv ----
/* self-checking bench for gpio_port with board model.
   assumes the defines header on the include path. */
`timescale 1ns/100ps
`include "gpio_port_defines.vh"
module tb_gpio_port;
    reg pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    reg pwrite = 1'h0, sys_clk_out = 1'h0, evt_ch0 = 1'h0;
    reg [7:0] paddr = 8'h00, ext = 8'h00, alt_en = 8'h00;
    reg [7:0] alt_out = 8'h00, alt_oe = 8'h00, e;
    reg [31:0] pwdata = 32'h0, cap, r, s = 32'h5D;
    wire [31:0] prdata;
    wire pready, pslverr, irq0, irq1, irq;
    wire [7:0] pin, pout, poe, pu, pd, ain;
    wire wake;
    int n_fail = 0;
    int samples_checked = 0;
    gpio_port u_gpio_port (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_pin_n_in(pin), .port_pin_n_out(pout), .port_pin_n_oe(poe),
        .pull_up_en(pu), .pull_dn_en(pd), .alt_en(alt_en),
        .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(ain),
        .sys_clk_out(sys_clk_out), .evt_ch0(evt_ch0), .wake_async(wake),
        .irq0(irq0), .irq1(irq1), .irq(irq));
    board_pins u_board_pins (.drv(pout), .oe(poe), .pu(pu), .pd(pd),
        .ext(ext), .pin(pin));
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) cap <= prdata;
    initial begin
        #100000;
        n_fail++;
        conclude;
    end
    function [31:0] lfsr(input [31:0] v);
        lfsr = {v[30:0], 1'h0} ^ (v[31] ? 32'h04C11DB7 : 32'h0);
    endfunction
    function [7:0] sct(input [31:0] v);
        sct = ((v[7:0] | v[15:8]) & ~v[23:16]) ^ v[31:24];
    endfunction
    task conclude;
        $display("checks %0d fails %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input string nm, input [31:0] ex, input [31:0] got);
        samples_checked++;
        if (got !== ex) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", nm, ex, got);
        end
    endtask
    task apb(input [7:0] ad, input [7:0] wd, input w = 1'h1);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
        #1 r = cap;
    endtask
    task rdc(input [7:0] ad, input [7:0] ex, input string nm);
        apb(ad, 8'h00, 1'h0);
        chk(nm, ex, r);
    endtask
    task hold(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        rdc(`OFF_DIR, 8'h00, "dir reset");
        for (int i = 0; i < 8; i++) begin
            s = lfsr(s);
            e = i[0] ? `OFF_OUT : `OFF_DIR;
            apb(e, s[7:0]);
            apb(e + 8'h04, s[15:8]);
            apb(e + 8'h08, s[23:16]);
            apb(e + 8'h0C, s[31:24]);
            rdc(e, sct(s), "set clr tgl");
        end
        apb(`OFF_DIR, 8'hFF);
        apb(`OFF_OUT, s[7:0]);
        apb(`OFF_CFG_SEL, 8'h06);
        apb(`OFF_CFG, 8'h20);
        chk("inv out", s[7:0] ^ 8'h06, pout);
        chk("oe on", 8'hFF, poe);
        ext <= s[15:8];
        apb(`OFF_DIR, 8'h00);
        rdc(`OFF_IN, s[15:8] ^ 8'h06, "inv in");
        chk("oe off", 8'h00, poe);
        apb(8'h40, 8'hFF);
        rdc(`OFF_DIR, 8'h00, "bad write");
        rdc(8'h40, 8'h00, "bad read");
        apb(`OFF_CFG_SEL, 8'hFF);
        apb(`OFF_MASK0, 8'h01);
        apb(`OFF_IRQ_EN, 8'h03);
        for (int m = 0; m < 4; m++) begin
            ext <= 8'hFF;
            apb(`OFF_CFG, m[7:0]);
            hold(4);
            apb(`OFF_STATUS, 8'h00, 1'h0);
            ext <= 8'h00;
            hold(4);
            chk("fall", m != 1, irq0);
            chk("irq1 off", 1'h0, irq1);
            apb(`OFF_STATUS, 8'h00, 1'h0);
            chk("clear", m == 3, irq0);
            ext <= 8'hFF;
            hold(4);
            chk("rise", m != 2, irq0);
        end
        apb(`OFF_MASK1, 8'h01);
        ext <= 8'h00;
        hold(4);
        chk("irq1 hit", 1'h1, irq1);
        apb(`OFF_IRQ_EN, 8'h01);
        chk("irq1 masked", 1'h0, irq1);
        ext <= 8'hFF;
        hold(4);
        apb(`OFF_STATUS, 8'h00, 1'h0);
        chk("irq clear", 1'h0, irq);
        apb(`OFF_CFG, 8'h00);
        apb(`OFF_DIR, 8'hFF);
        apb(`OFF_OUT, 8'h00);
        apb(`OFF_ROUTE, 8'h33);
        for (int v = 0; v < 2; v++) begin
            evt_ch0 <= v[0];
            sys_clk_out <= v[0];
            alt_en <= 8'h04;
            alt_oe <= 8'h04;
            alt_out <= {8{v[0]}};
            hold(2);
            chk("event pin", v[0], pout[7]);
            chk("clock pin", v[0], pout[3]);
            chk("alt pin", v[0], pout[2]);
        end
        alt_en <= 8'h00;
        apb(`OFF_ROUTE, 8'h00);
        apb(`OFF_DIR, 8'h00);
        apb(`OFF_CFG, 8'h08);
        chk("pull up", 8'hFF, pu);
        apb(`OFF_CFG, 8'h04);
        chk("pull down", 8'hFF, pd);
        apb(`OFF_CFG, 8'h0C);
        apb(`OFF_DIR, 8'hFF);
        apb(`OFF_OUT, 8'hAA);
        apb(`OFF_DIR, 8'h00);
        chk("keep up", 8'hAA, pu);
        chk("keep down", 8'h55, pd);
        rdc(`OFF_IN, 8'hAA, "keep level");
        apb(`OFF_CFG, 8'h10);
        apb(`OFF_DIR, 8'hFF);
        apb(`OFF_OUT, 8'h0F);
        chk("wor oe", 8'h0F, poe);
        chk("wor pd", 8'hFF, pd);
        apb(`OFF_CFG, 8'h14);
        chk("wand oe", 8'hF0, poe);
        chk("wand pu", 8'hFF, pu);
        apb(`OFF_DIR, 8'h00);
        apb(`OFF_CFG, 8'h03);
        ext <= 8'h00;
        hold(1);
        chk("wake low", 1'h1, wake);
        ext <= 8'hFF;
        hold(1);
        chk("wake idle", 1'h0, wake);
        ext <= 8'h00;
        apb(`OFF_CFG, 8'h20);
        hold(3);
        chk("alt in inv", 8'hFF, ain);
        alt_en <= 8'h04;
        alt_oe <= 8'h04;
        alt_out <= 8'h00;
        hold(1);
        chk("alt inv pin", 1'h1, pout[2]);
        chk("alt oe", 1'h1, poe[2]);
        conclude;
    end
endmodule
